// ==== rtl/stop_mode_recovery_control.sv ====
/*
  stop-mode recovery sequencer: stop entry, wake handling, watchdog enable
  across recovery, reset-pin function. assumes one clock, wake sources
  and the reset pin asynchronous, control inputs from same-clock logic.
*/
`include "stop_recovery_map.svh"
`default_nettype none
// Summary of operation
// RQ1 - a pending interrupt that wakes the device is discarded before recovery ends and its service is never entered.
// RQ2 - by specification recovery turns the watchdog off unless the always-on option is set.
// RQ3 - in this silicon recovery leaves the watchdog enable as it was, so the watchdog keeps running.
// RQ4 - software turns the watchdog oscillator off around stop and back on before the next stop entry.
// RQ5 - after reset the reset-capable pin is assigned to its reset function, on a package-dependent pin.
// RQ6 - with the reset-capable pin reassigned, recovery from stop does not complete correctly.
// RQ7 - software sets the reset-capable pin to its reset function before commanding stop.
// RQ8 - in stop the system clock is held off until a wake interrupt or reset pin assertion.
module stop_mode_recovery_control
  import stop_recovery_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       clk_en,
  input  wire logic       stop_request,
  input  wire logic       wake_irq_pin,
  input  wire logic       reset_pin_n,
  input  wire logic       watchdog_always_on_option,
  input  wire logic       spec_recovery,
  input  wire logic       package_small,
  input  wire logic       pin_func_write,
  input  wire logic [1:0] pin_func_data,
  input  wire logic       watchdog_enable_write,
  input  wire logic       watchdog_enable_data,
  input  wire logic       watchdog_osc_write,
  input  wire logic       watchdog_osc_data,
  output var  logic       system_clock_enable,
  output var  logic       irq_pending,
  output var  logic       irq_discard,
  output var  logic       reset_request,
  output var  logic       recovery_done,
  output var  logic       watchdog_timer_run,
  output var  logic [1:0] reset_pin_func,
  output var  logic       reset_on_pa_pin,
  output var  logic       reset_on_pd_pin,
  output var  power_status_t status
);
  recovery_state_t state;
  recovery_state_t next_state;
  logic       wake_level;
  logic       reset_level;
  logic       wake_prev;
  logic [3:0] restart_cnt;
  logic [3:0] next_restart_cnt;
  logic       wd_enable;
  logic       next_wd_enable;
  logic       wd_osc;
  logic       next_wd_osc;
  logic [1:0] next_pin_func;
  logic       next_irq_pending;
  logic       next_irq_discard;
  logic       next_reset_request;
  logic       next_recovery_done;
  logic       next_clock;
  logic       wake_rise;
  logic       wake_from_irq;
  logic       next_wake_from_irq;
  logic       pin_is_reset;

  pin_sync3 u_wake_sync (
    .clk      (clk),
    .srst     (srst),
    .clk_en   (clk_en),
    .async_in (wake_irq_pin),
    .level    (wake_level)
  );

  pin_sync3 u_reset_sync (
    .clk      (clk),
    .srst     (srst),
    .clk_en   (clk_en),
    .async_in (~reset_pin_n),
    .level    (reset_level)
  );

  assign wake_rise = wake_level & ~wake_prev;
  assign pin_is_reset = (reset_pin_func == `PIN_FUNC_RESET);

  always_comb begin
    next_state         = state;
    next_restart_cnt   = restart_cnt;
    next_wd_enable     = wd_enable;
    next_pin_func      = reset_pin_func;
    next_irq_pending   = irq_pending;
    next_irq_discard   = 1'h0;
    next_reset_request = 1'h0;
    next_recovery_done = 1'h0;
    next_clock         = system_clock_enable;
    next_wake_from_irq = wake_from_irq;
    unique case (state)
      st_run: begin
        next_clock = 1'h1;
        if (wake_rise) begin
          next_irq_pending = 1'h1;
        end
        if (pin_func_write) begin
          next_pin_func = pin_func_data;
        end
        if (watchdog_enable_write) begin
          next_wd_enable = watchdog_enable_data;
        end
        if (reset_level && pin_is_reset) begin
          next_reset_request = 1'h1;
        end else if (stop_request) begin
          next_state = st_stop;
          next_clock = 1'h0; // RQ8
        end
      end
      st_stop: begin
        next_clock = 1'h0; // RQ8
        if (wake_rise || (reset_level && pin_is_reset)) begin
          next_wake_from_irq = wake_rise;
          next_irq_pending   = irq_pending | wake_rise; // RQ1
          if (!pin_is_reset) begin
            next_state = st_stuck; // RQ6
          end else begin
            next_state       = st_restart;
            next_restart_cnt = `CLOCK_RESTART_CYC;
            next_clock       = 1'h1;
          end
        end
      end
      st_restart: begin
        next_clock = 1'h1;
        if (restart_cnt == `CLOCK_RESTART_ONE) begin
          next_state = st_finish;
        end
        next_restart_cnt = restart_cnt - `CLOCK_RESTART_ONE;
        if (wake_from_irq) begin
          next_irq_pending = 1'h0; // RQ1
          next_irq_discard = 1'h1; // RQ1
        end
      end
      st_finish: begin
        next_clock         = 1'h1;
        next_recovery_done = 1'h1;
        next_wake_from_irq = 1'h0;
        next_irq_pending   = 1'h0; // RQ1
        if (spec_recovery && !watchdog_always_on_option) begin
          next_wd_enable = 1'h0; // RQ2
        end else begin
          next_wd_enable = wd_enable; // RQ3
        end
        next_state = st_run;
      end
      st_stuck: begin
        next_clock = 1'h0; // RQ6
      end
      default: begin
        next_state = st_run;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state               <= st_run;
      restart_cnt         <= `CLOCK_RESTART_ZERO;
      wd_enable           <= 1'h0;
      reset_pin_func      <= `PIN_FUNC_RST_VAL; // RQ5
      irq_pending         <= 1'h0;
      irq_discard         <= 1'h0;
      reset_request       <= 1'h0;
      recovery_done       <= 1'h0;
      system_clock_enable <= 1'h1;
      wake_from_irq       <= 1'h0;
    end else if (clk_en) begin
      state               <= next_state;
      restart_cnt         <= next_restart_cnt;
      wd_enable           <= next_wd_enable;
      reset_pin_func      <= next_pin_func;
      irq_pending         <= next_irq_pending;
      irq_discard         <= next_irq_discard;
      reset_request       <= next_reset_request;
      recovery_done       <= next_recovery_done;
      system_clock_enable <= next_clock;
      wake_from_irq       <= next_wake_from_irq;
    end
  end

  // watchdog oscillator, written in any state
  always_comb begin
    next_wd_osc = wd_osc;
    if (watchdog_osc_write) begin
      next_wd_osc = watchdog_osc_data; // RQ4
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      wd_osc <= 1'h1;
    end else if (clk_en) begin
      wd_osc <= next_wd_osc;
    end
  end

  // wake edge detect, idles low like the pin
  always_ff @(posedge clk) begin
    if (srst) begin
      wake_prev <= 1'h0;
    end else if (clk_en) begin
      wake_prev <= wake_level;
    end
  end

  assign watchdog_timer_run = wd_enable & wd_osc;
  assign reset_on_pa_pin    = (package_small == `PKG_SMALL) && (reset_pin_func == `PIN_FUNC_RESET); // RQ5
  assign reset_on_pd_pin    = (package_small != `PKG_SMALL) && (reset_pin_func == `PIN_FUNC_RESET); // RQ5

  always_comb begin
    status.watchdog_enable     = wd_enable;
    status.watchdog_osc_enable = wd_osc;
    status.clock_run           = system_clock_enable;
    status.stop_active         = (state == st_stop) || (state == st_stuck);
  end
endmodule : stop_mode_recovery_control
`default_nettype wire

// ==== rtl/stop_recovery_map.svh ====
/*
  constants for the stop-mode recovery sequencer: pin function codes,
  stage counts and reset values. assumes inclusion by bare name.
*/
`ifndef STOP_RECOVERY_MAP_SVH
`define STOP_RECOVERY_MAP_SVH
`define PIN_FUNC_RESET      2'h0
`define PIN_FUNC_GPIO       2'h1
`define PIN_FUNC_ALT        2'h2
`define PIN_FUNC_RST_VAL    2'h0
`define WAKE_SYNC_STAGES    3
`define CLOCK_RESTART_CYC   4'h8
`define CLOCK_RESTART_ZERO  4'h0
`define CLOCK_RESTART_ONE   4'h1
`define PKG_SMALL           1'h1
`endif

// ==== rtl/stop_recovery_pkg.sv ====
/*
  types for the stop-mode recovery sequencer.
  assumes the map header is compiled alongside.
*/
`default_nettype none
package stop_recovery_pkg;
  typedef enum logic [2:0] {
    st_run     = 3'h0,
    st_stop    = 3'h1,
    st_restart = 3'h2,
    st_finish  = 3'h3,
    st_stuck   = 3'h4
  } recovery_state_t;

  typedef struct packed {
    logic       watchdog_enable;
    logic       watchdog_osc_enable;
    logic       clock_run;
    logic       stop_active;
  } power_status_t;
endpackage : stop_recovery_pkg
`default_nettype wire

// ==== rtl/pin_sync3.sv ====
/*
  three-stage synchroniser with agreement filter for asynchronous pins.
  assumes a single clock domain on clk.
*/
`default_nettype none
module pin_sync3 (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic clk_en,
  input  wire logic async_in,
  output var  logic level
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic       next_level;

  always_comb begin
    next_stage = {stage[1:0], async_in};
    next_level = (stage[1] == stage[2]) ? stage[2] : level;
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      stage <= 3'h0;
      level <= 1'h0;
    end else if (clk_en) begin
      stage <= next_stage;
      level <= next_level;
    end
  end
endmodule : pin_sync3
`default_nettype wire

// ==== tb/stop_recovery_monitor.sv ====
/*
  checker for the stop-mode recovery sequencer ports.
  assumes one clock, bound to the sequencer top.
*/
`include "stop_recovery_map.svh"
`default_nettype none
module stop_recovery_monitor
  import stop_recovery_pkg::*;
(
  input wire logic          clk,
  input wire logic          srst,
  input wire logic          wake_irq_pin,
  input wire logic          watchdog_always_on_option,
  input wire logic          spec_recovery,
  input wire logic          system_clock_enable,
  input wire logic          irq_pending,
  input wire logic          irq_discard,
  input wire logic          recovery_done,
  input wire logic [1:0]    reset_pin_func,
  input wire power_status_t status
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  stop_clock_a: assert property (status.stop_active |-> !system_clock_enable)
    else $error("clock runs in stop");
  wake_resume_a: assert property ($rose(wake_irq_pin) && status.stop_active
    && reset_pin_func == `PIN_FUNC_RESET |-> ##[2:8] system_clock_enable) else $error("no resume on wake");
  restart_len_a: assert property ($rose(system_clock_enable) |-> ##9 recovery_done)
    else $error("restart length wrong");
  irq_drop_a: assert property (irq_discard |-> !irq_pending) else $error("irq kept");
  done_drop_a: assert property ($fell(irq_discard) |-> recovery_done && !irq_pending)
    else $error("irq not discarded");
  wd_hold_a: assert property ((!spec_recovery || watchdog_always_on_option) && (irq_discard || recovery_done)
    |-> $stable(status.watchdog_enable) ##1 $stable(status.watchdog_enable)) else $error("wd enable moved");
  wd_clear_a: assert property (spec_recovery && !watchdog_always_on_option && recovery_done
    |-> ##[0:1] !status.watchdog_enable) else $error("wd not cleared");
  pin_reset_a: assert property ($fell(srst) |-> reset_pin_func == `PIN_FUNC_RESET)
    else $error("pin not reset func");
  bad_pin_a: assert property (status.stop_active && reset_pin_func != `PIN_FUNC_RESET
    |-> !recovery_done && !system_clock_enable) else $error("recovered with pin moved");
endmodule : stop_recovery_monitor
bind stop_mode_recovery_control stop_recovery_monitor u_stop_recovery_monitor (.*);
`default_nettype wire

// ==== tb/wake_source_model.sv ====
/*
  wake interrupt source and reset pin of the far side.
  assumes the reset pin is pulled up and idles released.
*/
`default_nettype none
module wake_source_model (
  input  wire logic clk,
  output var  logic wake_irq_pin,
  output var  logic reset_pin_n
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    wake_irq_pin = 1'h0;
    reset_pin_n  = 1'h1;
  end
  // wake edge held past the synchroniser
  task automatic wake_pulse(input int hold);
    @(posedge clk) #1 wake_irq_pin = 1'h1;
    repeat (hold) @(posedge clk);
    #1 wake_irq_pin = 1'h0;
  endtask : wake_pulse
  // reset pin pulled low, then released to the pull-up
  task automatic reset_press(input int hold);
    @(posedge clk) #1 reset_pin_n = 1'h0;
    repeat (hold) @(posedge clk);
    #1 reset_pin_n = 1'h1;
  endtask : reset_press
endmodule : wake_source_model
`default_nettype wire

// ==== tb/tb_stop_mode_recovery_control.sv ====
/*
  self-checking bench for the stop-mode recovery sequencer.
  assumes the wake model drives the pins, clk_en held high.
*/
`include "stop_recovery_map.svh"
`default_nettype none
module tb_stop_mode_recovery_control
  import stop_recovery_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic          clk = 1'h0, srst = 1'h1, clk_en = 1'h1, stop_request = 1'h0, package_small = 1'h1;
  logic          watchdog_always_on_option = 1'h0, spec_recovery = 1'h0, pin_func_write = 1'h0;
  logic          watchdog_enable_write = 1'h0, watchdog_enable_data = 1'h0;
  logic          watchdog_osc_write = 1'h0, watchdog_osc_data = 1'h0;
  logic [1:0]    pin_func_data = 2'h0, reset_pin_func;
  logic          wake_irq_pin, reset_pin_n, system_clock_enable, irq_pending, irq_discard, reset_request;
  logic          recovery_done, watchdog_timer_run, reset_on_pa_pin, reset_on_pd_pin;
  power_status_t status;
  int            err_count = 0, samples_checked = 0, discards = 0, pends = 0;
  always #4 clk = ~clk;
  always @(posedge clk) begin
    if (irq_discard === 1'h1) discards++;
    if (irq_pending === 1'h1) pends++;
  end
  stop_mode_recovery_control u_stop_mode_recovery_control (.*);
  wake_source_model u_wake_source_model (.*);
  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic cmd(ref logic strobe);
    strobe = 1'h1;
    tick(1);
    strobe = 1'h0;
  endtask : cmd
  task automatic pkg_pin();
    for (int p = 0; p < 2; p++) begin
      package_small = p[0];
      tick(1);
      check({reset_on_pa_pin, reset_on_pd_pin}, {p[0], ~p[0]});
    end
  endtask : pkg_pin
  task automatic wait_done();
    int n;
    for (n = 0; n < 50 && recovery_done !== 1'h1; n++) tick(1);
    if (n == 50) begin
      err_count++;
      end_of_test();
    end
  endtask : wait_done
  task automatic recover(input logic spec, input logic ao);
    spec_recovery = spec;
    watchdog_always_on_option = ao;
    watchdog_enable_data = 1'h1;
    cmd(watchdog_enable_write);
    pin_func_data = `PIN_FUNC_RESET;
    cmd(pin_func_write);
    discards = 0;
    pends = 0;
    cmd(stop_request);
    check({1'h0, system_clock_enable}, 2'h0);
    watchdog_osc_data = 1'h0;
    cmd(watchdog_osc_write);
    tick(20);
    check({status.stop_active, system_clock_enable}, 2'h2);
    u_wake_source_model.wake_pulse(6);
    wait_done();
    check({irq_pending, discards == `CLOCK_RESTART_CYC}, 2'h1);
    check({pends != 0, irq_discard}, 2'h2);
    tick(1);
    watchdog_osc_data = 1'h1;
    cmd(watchdog_osc_write);
    check({1'h0, watchdog_timer_run}, {1'h0, !(spec && !ao)});
  endtask : recover
  task automatic pin_wake();
    u_wake_source_model.reset_press(6);
    check({reset_request, status.stop_active}, 2'h2);
    tick(8);
    check({reset_request, system_clock_enable}, 2'h1);
    discards = 0;
    cmd(stop_request);
    u_wake_source_model.reset_press(6);
    wait_done();
    check({system_clock_enable, discards != 0}, 2'h2);
  endtask : pin_wake
  task automatic bad_pin(input logic [1:0] func);
    pin_func_data = func;
    cmd(pin_func_write);
    check({reset_on_pa_pin, reset_on_pd_pin}, 2'h0);
    cmd(stop_request);
    u_wake_source_model.wake_pulse(6);
    tick(20);
    check({system_clock_enable, recovery_done}, 2'h0);
    srst = 1'h1;
    tick(2);
    srst = 1'h0;
    tick(1);
    check(reset_pin_func, `PIN_FUNC_RESET);
  endtask : bad_pin
  initial begin
    tick(6);
    srst = 1'h0;
    tick(4);
    check(reset_pin_func, `PIN_FUNC_RESET);
    pkg_pin();
    recover(1'h0, 1'h0);
    recover(1'h1, 1'h0);
    recover(1'h1, 1'h1);
    pin_wake();
    bad_pin(`PIN_FUNC_GPIO);
    bad_pin(`PIN_FUNC_ALT);
    end_of_test();
  end
endmodule : tb_stop_mode_recovery_control
`default_nettype wire
